// file: rtl/otp_boot_pkg.sv
// constants for the boot copy and core clock divider
package otp_boot_pkg;
    localparam int OTP_ADDR_W      = 16;
    localparam int RAM_ADDR_W      = 13;
    localparam int DATA_W          = 8;
    localparam logic [15:0] OTP_BYTES       = 16'hffff; // last byte address of 64 KB
    localparam logic [15:0] PROG_SPACE_END  = 16'hdfff; // last byte of 56 KB program space
    localparam logic [15:0] IMAGE_BASE      = 16'he000; // start of 8 KB ram image
    localparam logic [12:0] RAM_LAST        = 13'h1fff;
    localparam logic [12:0] SHARED_BASE     = 13'h0000; // 0.5 KB shared data
    localparam logic [12:0] ENGINE_BASE     = 13'h0200; // 5.5 KB engine program
    localparam logic [12:0] LOCAL_BASE      = 13'h1800; // 2 KB core local data
    localparam int DIV_LSB         = 5;
    localparam int DIV_MSB         = 6;
    localparam logic [1:0] DIV_BY1 = 2'h0;
    localparam logic [1:0] DIV_BY2 = 2'h1;
    localparam logic [1:0] DIV_BY3 = 2'h2;
    localparam logic [1:0] DIV_BY4 = 2'h3;
    localparam logic [1:0] DIV_CNT_ZERO = 2'h0;
    localparam logic [1:0] CNT_ONE = 2'h1;
    localparam logic [2:0] BUF_DEPTH = 3'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_WAIT = 4'h4,
        ST_DONE = 4'h8
    } boot_state_t;
endpackage

// file: rtl/boot_skid_buffer.sv
// two-entry buffer between otp reads and ram writes
`timescale 1ns/1ps
`default_nettype none
module boot_skid_buffer
#(
    parameter int WIDTH = 21
)
(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic             clkEn,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    import otp_boot_pkg::*;

    logic [WIDTH-1:0] slot_r [2];
    logic [WIDTH-1:0] slot_nxt [2];
    logic             head_r;
    logic             head_nxt;
    logic [2:0]       count_r;
    logic [2:0]       count_nxt;
    logic             push;
    logic             pop;

    always_comb
    begin
        push        = inValid && (count_r != BUF_DEPTH);
        pop         = (count_r != 3'h0) && outReady;
        slot_nxt[0] = slot_r[0];
        slot_nxt[1] = slot_r[1];
        head_nxt    = head_r;
        count_nxt   = count_r;
        if (push)
        begin
            slot_nxt[head_r ^ count_r[0]] = inData;
        end
        if (pop)
        begin
            head_nxt = ~head_r;
        end
        if (push && !pop)
        begin
            count_nxt = count_r + 3'h1;
        end
        else if (pop && !push)
        begin
            count_nxt = count_r - 3'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            slot_r[0] <= '0;
            slot_r[1] <= '0;
            head_r    <= 1'b0;
            count_r   <= 3'h0;
        end
        else if (clkEn)
        begin
            slot_r[0] <= slot_nxt[0];
            slot_r[1] <= slot_nxt[1];
            head_r    <= head_nxt;
            count_r   <= count_nxt;
        end
    end

    // flags read straight off state so the fill side sees honest full
    assign inReady  = (count_r != BUF_DEPTH);
    assign outValid = (count_r != 3'h0);
    assign outData  = slot_r[head_r];
endmodule
`default_nettype wire

// file: rtl/otp_boot_clock_divider.sv
// boot copy from otp into ram and the core clock enable divider
// Notes on behaviour
// - one 64 KB otp holds core program and the ram image.
// - lower 56 KB is core program; upper region is the ram image.
// - ram splits into 0.5 KB shared, 5.5 KB engine program, 2 KB local.
// - at power-on without debugger copy last 8 KB of otp into ram.
// - debugger present skips the copy entirely.
// - core fetches from otp directly; program region never copied.
// - divide field bits 6:5 codes 00,01,10 give divide by 1,2,3.
// - code 11 gives divide by 4; engine stays on master clock.
// - motion engine always runs on the undivided master clock.
// - all other peripherals run on the divided core clock.
`timescale 1ns/1ps
`default_nettype none
module otp_boot_clock_divider
    import otp_boot_pkg::*;
(
    input  wire logic                             clk_sys,
    input  wire logic                             rst,
    input  wire logic                             clkEn,
    input  wire logic                             debuggerPresent,
    input  wire logic [7:0]                       pllDividerConfig,
    output logic                                  otpReadEn,
    output logic      [otp_boot_pkg::OTP_ADDR_W-1:0] otpAddr,
    input  wire logic                             otpDataValid,
    input  wire logic [otp_boot_pkg::DATA_W-1:0]  otpData,
    input  wire logic                             coreFetchEn,
    input  wire logic [otp_boot_pkg::OTP_ADDR_W-1:0] coreFetchAddr,
    output logic                                  coreFetchOk,
    output logic                                  ramWriteEn,
    output logic      [otp_boot_pkg::RAM_ADDR_W-1:0] ramAddr,
    output logic      [otp_boot_pkg::DATA_W-1:0]  ramData,
    output logic      [1:0]                       ramZone,
    input  wire logic                             ramReady,
    output logic                                  bootDone,
    output logic                                  bootSkipped,
    output logic                                  motionEngineRun,
    output logic                                  motionEngineClkEn,
    output logic                                  coreClkEn
);
    import otp_boot_pkg::*;

    localparam int BW = RAM_ADDR_W + DATA_W;

    boot_state_t                state_r;
    boot_state_t                state_nxt;
    logic [RAM_ADDR_W-1:0]      rdIdx_r;
    logic [RAM_ADDR_W-1:0]      rdIdx_nxt;
    logic                       rdLast_r;
    logic                       rdLast_nxt;
    logic                       otpReadEn_nxt;
    logic                       bootDone_r;
    logic                       bootDone_nxt;
    logic                       bootSkipped_r;
    logic                       bootSkipped_nxt;
    logic                       bufInReady;
    logic                       bufOutValid;
    logic [BW-1:0]              bufOutData;
    logic                       pendingIdle;
    logic [1:0]                 divCnt_r;
    logic [1:0]                 divCnt_nxt;
    logic                       coreClkEn_nxt;
    logic                       fetchOk_nxt;
    logic                       ramWe_nxt;
    logic [1:0]                 zone_nxt;
    logic [RAM_ADDR_W-1:0]      ramAddr_nxt;
    logic [DATA_W-1:0]          ramData_nxt;
    logic [1:0]                 divCode;
    logic [OTP_ADDR_W-1:0]      otpAddr_nxt;

    boot_skid_buffer #(.WIDTH(BW)) u_buf (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .clkEn    (clkEn),
        .inValid  (otpDataValid && state_r == ST_WAIT),
        .inReady  (bufInReady),
        .inData   ({rdIdx_r, otpData}),
        .outValid (bufOutValid),
        .outReady (ramReady || !ramWriteEn),
        .outData  (bufOutData)
    );

    // copy engine: one outstanding otp read, stalls while buffer is full
    always_comb
    begin
        state_nxt       = state_r;
        rdIdx_nxt       = rdIdx_r;
        rdLast_nxt      = rdLast_r;
        otpReadEn_nxt   = 1'b0;
        bootDone_nxt    = bootDone_r;
        bootSkipped_nxt = bootSkipped_r;
        pendingIdle     = !bufOutValid && !ramWriteEn;
        case (state_r)
            ST_IDLE:
            begin
                if (debuggerPresent)
                begin
                    bootSkipped_nxt = 1'b1;
                    bootDone_nxt    = 1'b1;
                    state_nxt       = ST_DONE;
                end
                else
                begin
                    rdIdx_nxt = '0;
                    state_nxt = ST_READ;
                end
            end
            ST_READ:
            begin
                if (bufInReady)
                begin
                    otpReadEn_nxt = 1'b1;
                    state_nxt     = ST_WAIT;
                end
            end
            ST_WAIT:
            begin
                otpReadEn_nxt = !(otpDataValid && bufInReady);
                if (otpDataValid && bufInReady)
                begin
                    rdLast_nxt = (rdIdx_r == RAM_LAST);
                    rdIdx_nxt  = rdIdx_r + 13'h1;
                    state_nxt  = (rdIdx_r == RAM_LAST) ? ST_DONE : ST_READ;
                end
                else if (otpDataValid)
                begin
                    otpReadEn_nxt = 1'b0;
                    state_nxt     = ST_READ;
                end
            end
            ST_DONE:
            begin
                if (!bootSkipped_r && rdLast_r && pendingIdle)
                begin
                    bootDone_nxt = 1'b1;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
        // image window at top of otp; registered so the address never glitches
        otpAddr_nxt = IMAGE_BASE + {3'h0, rdIdx_nxt};
    end

    // ram write side; zone tags the three ram areas
    always_comb
    begin
        ramWe_nxt   = ramWriteEn && !ramReady;
        ramAddr_nxt = ramAddr;
        ramData_nxt = ramData;
        zone_nxt    = ramZone;
        if (bufOutValid && (ramReady || !ramWriteEn))
        begin
            ramWe_nxt   = 1'b1;
            ramAddr_nxt = bufOutData[BW-1:DATA_W];
            ramData_nxt = bufOutData[DATA_W-1:0];
            if (bufOutData[BW-1:DATA_W] < ENGINE_BASE)
            begin
                zone_nxt = 2'h0;
            end
            else if (bufOutData[BW-1:DATA_W] < LOCAL_BASE)
            begin
                zone_nxt = 2'h1;
            end
            else
            begin
                zone_nxt = 2'h2;
            end
        end
    end

    // divider gives core and peripheral enable; engine enable always high
    always_comb
    begin
        divCode       = pllDividerConfig[DIV_MSB:DIV_LSB];
        coreClkEn_nxt = (divCnt_r == DIV_CNT_ZERO);
        case (divCode)
            DIV_BY1: divCnt_nxt = DIV_CNT_ZERO;
            DIV_BY2: divCnt_nxt = (divCnt_r >= CNT_ONE) ? DIV_CNT_ZERO : divCnt_r + CNT_ONE;
            DIV_BY3: divCnt_nxt = (divCnt_r >= 2'h2) ? DIV_CNT_ZERO : divCnt_r + CNT_ONE;
            DIV_BY4: divCnt_nxt = divCnt_r + CNT_ONE;
            default: divCnt_nxt = DIV_CNT_ZERO;
        endcase
        // core fetches only the program space, straight from otp
        fetchOk_nxt = coreFetchEn && (coreFetchAddr <= PROG_SPACE_END);
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_r           <= ST_IDLE;
            rdIdx_r           <= '0;
            rdLast_r          <= 1'b0;
            otpReadEn         <= 1'b0;
            otpAddr           <= IMAGE_BASE;
            bootDone_r        <= 1'b0;
            bootSkipped_r     <= 1'b0;
            ramWriteEn        <= 1'b0;
            ramAddr           <= '0;
            ramData           <= '0;
            ramZone           <= 2'h0;
            divCnt_r          <= DIV_CNT_ZERO;
            coreClkEn         <= 1'b0;
            coreFetchOk       <= 1'b0;
            motionEngineRun   <= 1'b0;
            motionEngineClkEn <= 1'b0;
        end
        else if (clkEn)
        begin
            state_r           <= state_nxt;
            rdIdx_r           <= rdIdx_nxt;
            rdLast_r          <= rdLast_nxt;
            otpReadEn         <= otpReadEn_nxt;
            otpAddr           <= otpAddr_nxt;
            bootDone_r        <= bootDone_nxt;
            bootSkipped_r     <= bootSkipped_nxt;
            ramWriteEn        <= ramWe_nxt;
            ramAddr           <= ramAddr_nxt;
            ramData           <= ramData_nxt;
            ramZone           <= zone_nxt;
            divCnt_r          <= divCnt_nxt;
            coreClkEn         <= coreClkEn_nxt;
            coreFetchOk       <= fetchOk_nxt;
            motionEngineRun   <= bootDone_nxt;
            motionEngineClkEn <= 1'b1;
        end
    end

    assign bootDone    = bootDone_r;
    assign bootSkipped = bootSkipped_r;

    AST_SKIP_NO_READ: assert property (@(posedge clk_sys) disable iff (rst)
        bootSkipped |-> !otpReadEn && !ramWriteEn)
        else $error("otp read while boot skipped");

    AST_ENGINE_HELD: assert property (@(posedge clk_sys) disable iff (rst)
        !bootDone |-> !motionEngineRun)
        else $error("engine ran before boot done");

    AST_ENGINE_CLK: assert property (@(posedge clk_sys) disable iff (rst)
        clkEn ##1 clkEn |=> motionEngineClkEn)
        else $error("engine clock gated");

    AST_FETCH_RANGE: assert property (@(posedge clk_sys) disable iff (rst)
        coreFetchOk |-> $past(coreFetchAddr) <= PROG_SPACE_END)
        else $error("fetch outside program space");

    AST_RAM_RANGE: assert property (@(posedge clk_sys) disable iff (rst)
        otpReadEn |-> otpAddr >= IMAGE_BASE)
        else $error("read below image base");

    AST_DIV1: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && pllDividerConfig[DIV_MSB:DIV_LSB] == DIV_BY1) [*2] |-> ##1 coreClkEn)
        else $error("divide by one missed a pulse");

    AST_DIV2: assert property (@(posedge clk_sys) disable iff (rst)
        (clkEn && pllDividerConfig[DIV_MSB:DIV_LSB] == DIV_BY2) [*4] |-> ##1
        (coreClkEn != $past(coreClkEn)))
        else $error("divide by two not alternating");

    // steady divide by four run ending in a core pulse
    sequence seqDiv4Pulse;
        (clkEn && pllDividerConfig[DIV_MSB:DIV_LSB] == DIV_BY4) [*5] ##0 coreClkEn;
    endsequence

    // a code change alters the count's wrap point, so it releases the check
    AST_DIV4: assert property (@(posedge clk_sys) disable iff (rst)
        seqDiv4Pulse |=> (!coreClkEn || pllDividerConfig[DIV_MSB:DIV_LSB] != DIV_BY4) [*3])
        else $error("divide by four pulse too close");

    AST_ZONE: assert property (@(posedge clk_sys) disable iff (rst)
        ramWriteEn && ramAddr < ENGINE_BASE |-> ramZone == 2'h0)
        else $error("shared zone mislabeled");
endmodule
`default_nettype wire

// file: test/otp_array_model.sv
// behavioural otp array answering the boot copy reads
`timescale 1ns/1ps
`default_nettype none
module otp_array_model
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        otpReadEn,
    input  wire logic [15:0] otpAddr,
    output logic             otpDataValid,
    output logic      [7:0]  otpData
);
    logic [1:0] waitCnt;

    // every other group of eight bytes answers three cycles late
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            otpDataValid <= 1'b0;
            otpData      <= 8'h00;
            waitCnt      <= 2'h0;
        end
        else
        begin
            otpDataValid <= 1'b0;
            otpData      <= ~otpData; // idle bus never keeps the old byte
            if (otpReadEn && !otpDataValid)
            begin
                if (waitCnt == {2{otpAddr[3]}})
                begin
                    otpDataValid <= 1'b1;
                    otpData      <= otpAddr[7:0] ^ otpAddr[15:8] ^ 8'h5a;
                    waitCnt      <= 2'h0;
                end
                else
                begin
                    waitCnt <= waitCnt + 2'h1;
                end
            end
        end
    end
endmodule
`default_nettype wire

// file: test/otp_boot_clock_divider_bench.sv
// self-checking bench for the boot copy and the core clock divider
`timescale 1ns/1ps
`default_nettype none
module otp_boot_clock_divider_bench;
    import otp_boot_pkg::*;
    logic        clk_sys = 1'b0, rst = 1'b1, clkEn = 1'b1, debuggerPresent = 1'b0;
    logic [7:0]  pllDividerConfig = 8'h00;
    logic        coreFetchEn = 1'b0, ramReady = 1'b1, copying = 1'b0;
    logic [15:0] coreFetchAddr = 16'h0000;
    logic [15:0] otpAddr;
    logic [12:0] ramAddr;
    logic [7:0]  otpData, ramData;
    logic [1:0]  ramZone;
    logic        otpReadEn, otpDataValid, coreFetchOk, ramWriteEn, bootDone, bootSkipped;
    logic        motionEngineRun, motionEngineClkEn, coreClkEn;
    int          n_fail = 0, checks_done = 0, cycles = 0, wrIdx = 0, nValid = 0;

    otp_boot_clock_divider i_otp_boot_clock_divider (.clk_sys(clk_sys), .rst(rst),
        .clkEn(clkEn), .debuggerPresent(debuggerPresent), .pllDividerConfig(pllDividerConfig),
        .otpReadEn(otpReadEn), .otpAddr(otpAddr), .otpDataValid(otpDataValid),
        .otpData(otpData), .coreFetchEn(coreFetchEn), .coreFetchAddr(coreFetchAddr),
        .coreFetchOk(coreFetchOk), .ramWriteEn(ramWriteEn), .ramAddr(ramAddr),
        .ramData(ramData), .ramZone(ramZone), .ramReady(ramReady), .bootDone(bootDone),
        .bootSkipped(bootSkipped), .motionEngineRun(motionEngineRun),
        .motionEngineClkEn(motionEngineClkEn), .coreClkEn(coreClkEn));
    otp_array_model i_otp_array_model (.clk_sys(clk_sys), .rst(rst), .otpReadEn(otpReadEn),
        .otpAddr(otpAddr), .otpDataValid(otpDataValid), .otpData(otpData));

    always #5 clk_sys = ~clk_sys;

    task automatic checkBit(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: %s got %b", $time, what, got);
        end
    endtask

    task automatic checkVal(input logic [15:0] got, input logic [15:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic conclude;
        $display("comparisons %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    function automatic logic [1:0] zoneOf(input int idx);
        return (idx < 16'h0200) ? 2'h0 : (idx < 16'h1800) ? 2'h1 : 2'h2;
    endfunction

    // stalls by ram and clock enable only while the copy runs
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 90000)
        begin
            n_fail++;
            conclude;
        end
        ramReady <= copying ? (cycles % 7 != 3) : 1'b1;
        clkEn    <= copying ? (cycles % 13 != 5) : 1'b1;
    end

    always @(posedge clk_sys)
    begin
        if (!rst)
        begin
            if (otpDataValid)
                nValid++;
            checkBit(motionEngineRun && !bootDone, 1'b0, "engine early");
            if (otpReadEn)
                checkBit(otpAddr >= IMAGE_BASE, 1'b1, "read below image");
            if (clkEn && ramWriteEn && ramReady)
            begin
                checkVal({3'h0, ramAddr}, wrIdx[15:0], "ram addr");
                checkVal({8'h00, ramData}, {8'h00, wrIdx[7:0] ^ (8'he0 + wrIdx[15:8]) ^ 8'h5a},
                    "ram data");
                checkVal({14'h0, ramZone}, {14'h0, zoneOf(wrIdx)}, "ram zone");
                wrIdx++;
            end
        end
    end

    task automatic doReset(input logic dbg);
        debuggerPresent <= dbg;
        rst             <= 1'b1;
        repeat (2) @(posedge clk_sys);
        rst   <= 1'b0;
        wrIdx = 0;
        nValid = 0;
    endtask

    task automatic skipTest;
        @(posedge clk_sys);
        doReset(1'b1);
        repeat (3) @(posedge clk_sys);
        #1;
        checkBit(bootDone, 1'b1, "skip done");
        checkBit(bootSkipped, 1'b1, "skip flag");
        checkBit(motionEngineRun, 1'b1, "engine run");
        repeat (20) @(posedge clk_sys);
        checkVal(wrIdx[15:0], 16'h0000, "ram writes");
        checkVal(nValid[15:0], 16'h0000, "otp reads");
    endtask

    // other config bits set high: only the divide field may matter
    task automatic divTest(input logic [1:0] code, input int n);
        int pulses;
        pulses = 0;
        @(posedge clk_sys);
        pllDividerConfig <= {1'b1, code, 5'h1f};
        repeat (8) @(posedge clk_sys);
        repeat (24)
        begin
            @(posedge clk_sys);
            #1;
            if (coreClkEn === 1'b1)
                pulses++;
            checkBit(motionEngineClkEn, 1'b1, "engine clock");
        end
        checkVal(pulses[15:0], 16'(24 / n), "core pulses");
    endtask

    // back-to-back fetches straddling the program space boundary
    task automatic fetchTest;
        logic [15:0] addrs [3] = '{16'hdfff, 16'he000, 16'h0000};
        logic        expOk;
        for (int i = 0; i < 5; i++)
        begin
            @(posedge clk_sys);
            coreFetchEn   <= (i < 3);
            coreFetchAddr <= addrs[i % 3];
            #1;
            // last step has no request behind it, so no grant is wanted
            expOk = (i < 4) && (addrs[(i + 2) % 3] <= PROG_SPACE_END);
            if (i > 0)
                checkBit(coreFetchOk, expOk, "fetch ok");
        end
    endtask

    task automatic copyTest;
        @(posedge clk_sys);
        pllDividerConfig <= 8'h60;
        doReset(1'b0);
        copying = 1'b1;
        for (int k = 0; k < 85000 && bootDone !== 1'b1; k++)
        begin
            @(posedge clk_sys);
            checkBit(motionEngineRun && wrIdx < 32'h2000, 1'b0, "engine before copy");
        end
        copying = 1'b0;
        repeat (3) @(posedge clk_sys);
        #1;
        checkBit(bootDone, 1'b1, "copy done");
        checkVal(wrIdx[15:0], 16'h2000, "bytes copied");
        checkBit(bootSkipped, 1'b0, "skip flag");
        checkBit(motionEngineRun, 1'b1, "engine run");
    endtask

    initial
    begin
        skipTest;
        divTest(DIV_BY1, 1);
        divTest(DIV_BY2, 2);
        divTest(DIV_BY3, 3);
        divTest(DIV_BY4, 4);
        fetchTest;
        copyTest;
        conclude;
    end
endmodule
`default_nettype wire
